// ### shared/umc_defines.svh
// constants for the mode and rate configuration block
`ifndef UMC_DEFINES_SVH
`define UMC_DEFINES_SVH

// ************************************************************
// register addressing (a1,a0) and reset value
// ************************************************************
`define UMC_ADDR_MODE 2'h2
`define UMC_ADDR_CMD 2'h3
`define UMC_MODE_RESET 8'h00

// ************************************************************
// format_mode_config field positions
// ************************************************************
`define UMC_FMT_LSB 0
`define UMC_LEN_LSB 2
`define UMC_PAR_EN_BIT 4
`define UMC_PAR_TYPE_BIT 5
`define UMC_STOP_LSB 6
`define UMC_TRANSP_BIT 6
`define UMC_SYNC_CNT_BIT 7

// ************************************************************
// clock_rate_config field positions
// ************************************************************
`define UMC_RATE_LSB 0
`define UMC_RX_SEL_BIT 4
`define UMC_TX_SEL_BIT 5

// ************************************************************
// rate generator divisors of the reference clock
// ************************************************************
`define UMC_DIV_0 13'h18c0
`define UMC_DIV_1 13'h1080
`define UMC_DIV_2 13'h0b40
`define UMC_DIV_3 13'h0933
`define UMC_DIV_4 13'h0840
`define UMC_DIV_5 13'h0420
`define UMC_DIV_6 13'h0210
`define UMC_DIV_7 13'h0108
`define UMC_DIV_8 13'h00b0
`define UMC_DIV_9 13'h009e
`define UMC_DIV_10 13'h0084
`define UMC_DIV_11 13'h0058
`define UMC_DIV_12 13'h0042
`define UMC_DIV_13 13'h002c
`define UMC_DIV_14 13'h0021
`define UMC_DIV_15 13'h0010

`endif

// ### shared/umc_pkg.sv
// types of the mode and rate configuration block
package umc_pkg;

    // clock multiplier seen by one direction
    typedef enum logic [1:0] {
        UMC_F1X = 2'h0,
        UMC_F16X = 2'h1,
        UMC_F64X = 2'h2
    } umc_factor_e;

    // stop bit framing
    typedef enum logic [1:0] {
        UMC_STOP_BAD = 2'h0,
        UMC_STOP_1 = 2'h1,
        UMC_STOP_1P5 = 2'h2,
        UMC_STOP_2 = 2'h3
    } umc_stop_e;

    // rate word handshake sender
    typedef enum logic [1:0] {
        UMC_HS_IDLE = 2'b01,
        UMC_HS_BUSY = 2'b10
    } umc_hs_e;

endpackage

// ### hdl/umc_pair_buffer.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module umc_pair_buffer #(
    parameter int WIDTH = 4
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    logic [WIDTH-1:0] slot0_ff, nxt_slot0;
    logic [WIDTH-1:0] slot1_ff, nxt_slot1;
    logic [1:0] count_ff, nxt_count;
    logic push;
    logic pop;

    assign o_in_ready = (count_ff != 2'h2);
    assign o_out_valid = (count_ff != 2'h0);
    assign o_out_data = slot0_ff;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        nxt_slot0 = slot0_ff;
        nxt_slot1 = slot1_ff;
        nxt_count = count_ff;
        if (pop) begin
            nxt_slot0 = slot1_ff;
        end
        if (push) begin
            if (count_ff == 2'h0 || (count_ff == 2'h1 && pop)) begin
                nxt_slot0 = i_in_data;
            end else begin
                nxt_slot1 = i_in_data;
            end
        end
        if (push && !pop) begin
            nxt_count = count_ff + 2'h1;
        end else if (pop && !push) begin
            nxt_count = count_ff - 2'h1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            slot0_ff <= '0;
            slot1_ff <= '0;
            count_ff <= 2'h0;
        end else begin
            slot0_ff <= nxt_slot0;
            slot1_ff <= nxt_slot1;
            count_ff <= nxt_count;
        end
    end

endmodule

`default_nettype wire

// ### hdl/umc_mode_rate.sv
// mode registers, format decode and internal rate generator
`timescale 1ns/1ps
`default_nettype none
`include "umc_defines.svh"

module umc_mode_rate (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_rate_ref_clk,
    input wire logic i_ce_b,
    input wire logic i_write,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rdata_oe,
    input wire logic i_tx_clk_pin,
    output logic o_tx_clk_pin,
    output logic o_tx_clk_pin_oe,
    input wire logic i_rx_clk_pin,
    output logic o_rx_clk_pin,
    output logic o_rx_clk_pin_oe,
    output logic o_tx_clk_level,
    output logic o_rx_clk_level,
    output logic o_sync_mode,
    output umc_pkg::umc_factor_e o_tx_factor,
    output umc_pkg::umc_factor_e o_rx_factor,
    output logic [3:0] o_char_bits,
    output logic o_parity_en,
    output logic o_parity_even,
    output umc_pkg::umc_stop_e o_tx_stop,
    output umc_pkg::umc_stop_e o_rx_stop,
    output logic o_sync_single,
    output logic o_transparent,
    output logic o_fill_escape,
    output logic o_escape_strip_en,
    output logic o_escape_detect_en,
    output logic o_rate_tick
);
    import umc_pkg::*;

    // ************************************************************
    // register access
    // ************************************************************
    logic [7:0] format_mode_config_ff, nxt_format_mode_config;
    logic [7:0] clock_rate_config_ff, nxt_clock_rate_config;
    logic mode_ptr_ff, nxt_mode_ptr;
    logic [7:0] rdata_ff, nxt_rdata;
    logic rdata_oe_ff, nxt_rdata_oe;
    logic rate_pending_ff, nxt_rate_pending;
    logic mode_acc;
    logic cmd_read;

    assign mode_acc = !i_ce_b && (i_addr == `UMC_ADDR_MODE);
    assign cmd_read = !i_ce_b && (i_addr == `UMC_ADDR_CMD) && !i_write;

    logic buf_in_ready;

    always_comb begin
        nxt_format_mode_config = format_mode_config_ff;
        nxt_clock_rate_config = clock_rate_config_ff;
        nxt_mode_ptr = mode_ptr_ff;
        nxt_rdata = 8'h00;
        nxt_rdata_oe = 1'b0;
        nxt_rate_pending = rate_pending_ff;
        if (rate_pending_ff && buf_in_ready) begin
            nxt_rate_pending = 1'b0;
        end
        if (mode_acc) begin
            nxt_mode_ptr = !mode_ptr_ff;
            if (i_write) begin
                if (mode_ptr_ff) begin
                    nxt_clock_rate_config = i_wdata;
                    nxt_rate_pending = 1'b1;
                end else begin
                    nxt_format_mode_config = i_wdata;
                end
            end else begin
                nxt_rdata = mode_ptr_ff ? clock_rate_config_ff : format_mode_config_ff;
                nxt_rdata_oe = 1'b1;
            end
        end else if (cmd_read) begin
            nxt_mode_ptr = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            format_mode_config_ff <= `UMC_MODE_RESET;
            clock_rate_config_ff <= `UMC_MODE_RESET;
            mode_ptr_ff <= 1'b0;
            rdata_ff <= 8'h00;
            rdata_oe_ff <= 1'b0;
            rate_pending_ff <= 1'b0;
        end else begin
            format_mode_config_ff <= nxt_format_mode_config;
            clock_rate_config_ff <= nxt_clock_rate_config;
            mode_ptr_ff <= nxt_mode_ptr;
            rdata_ff <= nxt_rdata;
            rdata_oe_ff <= nxt_rdata_oe;
            rate_pending_ff <= nxt_rate_pending;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_rdata_oe = rdata_oe_ff;

    // ************************************************************
    // format decode
    // ************************************************************
    logic [1:0] fmt;
    logic [1:0] stop_code;
    logic tx_int;
    logic rx_int;
    umc_factor_e async_factor;
    umc_stop_e stop_dec;

    assign fmt = format_mode_config_ff[`UMC_FMT_LSB +: 2];
    assign stop_code = format_mode_config_ff[`UMC_STOP_LSB +: 2];
    assign tx_int = clock_rate_config_ff[`UMC_TX_SEL_BIT];
    assign rx_int = clock_rate_config_ff[`UMC_RX_SEL_BIT];

    logic sync_mode_ff, nxt_sync_mode;
    umc_factor_e tx_factor_ff, nxt_tx_factor;
    umc_factor_e rx_factor_ff, nxt_rx_factor;
    logic [3:0] char_bits_ff, nxt_char_bits;
    logic parity_en_ff, nxt_parity_en;
    logic parity_even_ff, nxt_parity_even;
    umc_stop_e tx_stop_ff, nxt_tx_stop;
    umc_stop_e rx_stop_ff, nxt_rx_stop;
    logic sync_single_ff, nxt_sync_single;
    logic transparent_ff, nxt_transparent;
    logic fill_escape_ff, nxt_fill_escape;
    logic escape_strip_ff, nxt_escape_strip;
    logic escape_detect_ff, nxt_escape_detect;
    logic tx_pin_oe_ff, nxt_tx_pin_oe;
    logic rx_pin_oe_ff, nxt_rx_pin_oe;

    always_comb begin
        unique case (fmt)
            2'h3: async_factor = UMC_F64X;
            2'h2: async_factor = UMC_F16X;
            default: async_factor = UMC_F1X;
        endcase
        unique case (stop_code)
            2'h1: stop_dec = UMC_STOP_1;
            2'h2: stop_dec = UMC_STOP_1P5;
            2'h3: stop_dec = UMC_STOP_2;
            default: stop_dec = UMC_STOP_BAD;
        endcase
        nxt_sync_mode = (fmt == 2'h0);
        nxt_tx_factor = UMC_F1X;
        nxt_rx_factor = UMC_F1X;
        nxt_tx_stop = UMC_STOP_BAD;
        nxt_rx_stop = UMC_STOP_BAD;
        nxt_sync_single = 1'b0;
        nxt_transparent = 1'b0;
        nxt_fill_escape = 1'b0;
        nxt_escape_strip = 1'b0;
        nxt_escape_detect = 1'b0;
        nxt_parity_en = format_mode_config_ff[`UMC_PAR_EN_BIT];
        nxt_parity_even = nxt_parity_en && format_mode_config_ff[`UMC_PAR_TYPE_BIT];
        nxt_char_bits = 4'h5 + {2'h0, format_mode_config_ff[`UMC_LEN_LSB +: 2]};
        if (nxt_sync_mode) begin
            nxt_sync_single = format_mode_config_ff[`UMC_SYNC_CNT_BIT];
            nxt_transparent = format_mode_config_ff[`UMC_TRANSP_BIT];
            nxt_fill_escape = nxt_transparent;
            nxt_escape_strip = nxt_transparent;
            nxt_escape_detect = nxt_transparent && !nxt_parity_en;
        end else begin
            nxt_tx_factor = tx_int ? UMC_F16X : async_factor;
            nxt_rx_factor = rx_int ? UMC_F16X : async_factor;
            nxt_rx_stop = stop_dec;
            nxt_tx_stop = stop_dec;
            if (stop_dec == UMC_STOP_1P5 && nxt_tx_factor == UMC_F1X) begin
                nxt_tx_stop = UMC_STOP_1;
            end
        end
        nxt_tx_pin_oe = tx_int;
        nxt_rx_pin_oe = rx_int;
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_mode_ff <= 1'b1;
            tx_factor_ff <= UMC_F1X;
            rx_factor_ff <= UMC_F1X;
            char_bits_ff <= 4'h5;
            parity_en_ff <= 1'b0;
            parity_even_ff <= 1'b0;
            tx_stop_ff <= UMC_STOP_BAD;
            rx_stop_ff <= UMC_STOP_BAD;
            sync_single_ff <= 1'b0;
            transparent_ff <= 1'b0;
            fill_escape_ff <= 1'b0;
            escape_strip_ff <= 1'b0;
            escape_detect_ff <= 1'b0;
            tx_pin_oe_ff <= 1'b0;
            rx_pin_oe_ff <= 1'b0;
        end else begin
            sync_mode_ff <= nxt_sync_mode;
            tx_factor_ff <= nxt_tx_factor;
            rx_factor_ff <= nxt_rx_factor;
            char_bits_ff <= nxt_char_bits;
            parity_en_ff <= nxt_parity_en;
            parity_even_ff <= nxt_parity_even;
            tx_stop_ff <= nxt_tx_stop;
            rx_stop_ff <= nxt_rx_stop;
            sync_single_ff <= nxt_sync_single;
            transparent_ff <= nxt_transparent;
            fill_escape_ff <= nxt_fill_escape;
            escape_strip_ff <= nxt_escape_strip;
            escape_detect_ff <= nxt_escape_detect;
            tx_pin_oe_ff <= nxt_tx_pin_oe;
            rx_pin_oe_ff <= nxt_rx_pin_oe;
        end
    end

    assign o_sync_mode = sync_mode_ff;
    assign o_tx_factor = tx_factor_ff;
    assign o_rx_factor = rx_factor_ff;
    assign o_char_bits = char_bits_ff;
    assign o_parity_en = parity_en_ff;
    assign o_parity_even = parity_even_ff;
    assign o_tx_stop = tx_stop_ff;
    assign o_rx_stop = rx_stop_ff;
    assign o_sync_single = sync_single_ff;
    assign o_transparent = transparent_ff;
    assign o_fill_escape = fill_escape_ff;
    assign o_escape_strip_en = escape_strip_ff;
    assign o_escape_detect_en = escape_detect_ff;
    assign o_tx_clk_pin_oe = tx_pin_oe_ff;
    assign o_rx_clk_pin_oe = rx_pin_oe_ff;

    // ************************************************************
    // rate word buffer and handshake toward the reference domain
    // ************************************************************
    logic buf_out_valid;
    logic [3:0] buf_out_data;
    umc_hs_e hs_state_ff, nxt_hs_state;
    logic [3:0] hs_data_ff, nxt_hs_data;
    logic hs_req_ff, nxt_hs_req;
    logic ack_s1_ff, ack_s2_ff;
    logic ref_ack_ff;

    // a second rate write while the crossing is busy waits in u_rate_buf
    umc_pair_buffer #(.WIDTH(4)) u_rate_buf (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_in_valid(rate_pending_ff),
        .o_in_ready(buf_in_ready),
        .i_in_data(clock_rate_config_ff[`UMC_RATE_LSB +: 4]),
        .o_out_valid(buf_out_valid),
        .i_out_ready(hs_state_ff == UMC_HS_IDLE),
        .o_out_data(buf_out_data)
    );

    always_comb begin
        nxt_hs_state = hs_state_ff;
        nxt_hs_data = hs_data_ff;
        nxt_hs_req = hs_req_ff;
        unique case (hs_state_ff)
            UMC_HS_IDLE: begin
                if (buf_out_valid) begin
                    nxt_hs_data = buf_out_data;
                    nxt_hs_req = !hs_req_ff;
                    nxt_hs_state = UMC_HS_BUSY;
                end
            end
            UMC_HS_BUSY: begin
                if (ack_s2_ff == hs_req_ff) begin
                    nxt_hs_state = UMC_HS_IDLE;
                end
            end
            default: nxt_hs_state = UMC_HS_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hs_state_ff <= UMC_HS_IDLE;
            hs_data_ff <= 4'h0;
            hs_req_ff <= 1'b0;
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
        end else begin
            hs_state_ff <= nxt_hs_state;
            hs_data_ff <= nxt_hs_data;
            hs_req_ff <= nxt_hs_req;
            ack_s1_ff <= ref_ack_ff;
            ack_s2_ff <= ack_s1_ff;
        end
    end

    // ************************************************************
    // reference clock domain: reset release, rate capture, divider
    // ************************************************************
    logic ref_rst_s1_ff, ref_rst_b_ff;
    logic req_s1_ff, req_s2_ff, req_s3_ff, nxt_ref_ack;
    logic [3:0] ref_rate_ff, nxt_ref_rate;
    logic [12:0] ref_cnt_ff, nxt_ref_cnt;
    logic [3:0] ref_phase_ff, nxt_ref_phase;
    logic ref_tick_tgl_ff, nxt_ref_tick_tgl;
    logic [12:0] ref_div;

    always_ff @(posedge i_rate_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ref_rst_s1_ff <= 1'b0;
            ref_rst_b_ff <= 1'b0;
        end else begin
            ref_rst_s1_ff <= 1'b1;
            ref_rst_b_ff <= ref_rst_s1_ff;
        end
    end

    always_comb begin
        unique case (ref_rate_ff)
            4'h0: ref_div = `UMC_DIV_0;
            4'h1: ref_div = `UMC_DIV_1;
            4'h2: ref_div = `UMC_DIV_2;
            4'h3: ref_div = `UMC_DIV_3;
            4'h4: ref_div = `UMC_DIV_4;
            4'h5: ref_div = `UMC_DIV_5;
            4'h6: ref_div = `UMC_DIV_6;
            4'h7: ref_div = `UMC_DIV_7;
            4'h8: ref_div = `UMC_DIV_8;
            4'h9: ref_div = `UMC_DIV_9;
            4'ha: ref_div = `UMC_DIV_10;
            4'hb: ref_div = `UMC_DIV_11;
            4'hc: ref_div = `UMC_DIV_12;
            4'hd: ref_div = `UMC_DIV_13;
            4'he: ref_div = `UMC_DIV_14;
            4'hf: ref_div = `UMC_DIV_15;
        endcase
        nxt_ref_rate = ref_rate_ff;
        nxt_ref_ack = ref_ack_ff;
        nxt_ref_cnt = ref_cnt_ff + 13'h0001;
        nxt_ref_phase = ref_phase_ff;
        nxt_ref_tick_tgl = ref_tick_tgl_ff;
        // request word is held stable by the sender until acknowledged
        if (req_s2_ff != req_s3_ff) begin
            nxt_ref_rate = hs_data_ff;
            nxt_ref_ack = req_s2_ff;
            nxt_ref_cnt = 13'h0000;
        end else if (ref_cnt_ff >= ref_div - 13'h0001) begin
            nxt_ref_cnt = 13'h0000;
            nxt_ref_phase = ref_phase_ff + 4'h1;
            nxt_ref_tick_tgl = !ref_tick_tgl_ff;
        end
    end

    always_ff @(posedge i_rate_ref_clk or negedge ref_rst_b_ff) begin
        if (!ref_rst_b_ff) begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            req_s3_ff <= 1'b0;
            ref_ack_ff <= 1'b0;
            ref_rate_ff <= 4'h0;
            ref_cnt_ff <= 13'h0000;
            ref_phase_ff <= 4'h0;
            ref_tick_tgl_ff <= 1'b0;
        end else begin
            req_s1_ff <= hs_req_ff;
            req_s2_ff <= req_s1_ff;
            req_s3_ff <= req_s2_ff;
            ref_ack_ff <= nxt_ref_ack;
            ref_rate_ff <= nxt_ref_rate;
            ref_cnt_ff <= nxt_ref_cnt;
            ref_phase_ff <= nxt_ref_phase;
            ref_tick_tgl_ff <= nxt_ref_tick_tgl;
        end
    end

    // 1X clock: sixteen 16X ticks per period
    assign o_tx_clk_pin = ref_phase_ff[3];
    assign o_rx_clk_pin = ref_phase_ff[3];

    // ************************************************************
    // pin levels and 16X tick back in the system domain
    // ************************************************************
    logic tick_s1_ff, tick_s2_ff, tick_s3_ff, tick_ff;
    logic txp_s1_ff, txp_s2_ff, rxp_s1_ff, rxp_s2_ff;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_s1_ff <= 1'b0;
            tick_s2_ff <= 1'b0;
            tick_s3_ff <= 1'b0;
            tick_ff <= 1'b0;
            txp_s1_ff <= 1'b0;
            txp_s2_ff <= 1'b0;
            rxp_s1_ff <= 1'b0;
            rxp_s2_ff <= 1'b0;
        end else begin
            tick_s1_ff <= ref_tick_tgl_ff;
            tick_s2_ff <= tick_s1_ff;
            tick_s3_ff <= tick_s2_ff;
            tick_ff <= tick_s2_ff ^ tick_s3_ff;
            txp_s1_ff <= i_tx_clk_pin;
            txp_s2_ff <= txp_s1_ff;
            rxp_s1_ff <= i_rx_clk_pin;
            rxp_s2_ff <= rxp_s1_ff;
        end
    end

    assign o_rate_tick = tick_ff;
    assign o_tx_clk_level = txp_s2_ff;
    assign o_rx_clk_level = rxp_s2_ff;

endmodule

`default_nettype wire

// ### tb/umc_far_end.sv
// far end model driving the external clock pins
`timescale 1ns/1ps
`default_nettype none
module umc_far_end #(
    parameter int HALF_NS = 200
) (
    input wire logic i_run,
    output logic o_tx_clk,
    output logic o_rx_clk
);
    // clocks stand still high between frames
    initial begin
        o_tx_clk = 1'b1;
        o_rx_clk = 1'b1;
        forever begin
            if (i_run) begin
                #HALF_NS;
                o_tx_clk = ~o_tx_clk;
                o_rx_clk = o_tx_clk;
            end else begin
                o_tx_clk = 1'b1;
                o_rx_clk = 1'b1;
                @(i_run);
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/umc_mode_rate_chk.sv
// bound checker for the mode and rate block
`timescale 1ns/1ps
`default_nettype none
`include "umc_defines.svh"
module umc_mode_rate_chk (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_ce_b,
    input wire logic i_write,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] o_rdata,
    input wire logic o_rdata_oe,
    input wire logic o_rx_clk_pin_oe,
    input wire logic o_sync_mode,
    input wire umc_pkg::umc_factor_e o_tx_factor,
    input wire umc_pkg::umc_factor_e o_rx_factor,
    input wire logic [3:0] o_char_bits,
    input wire logic o_parity_en,
    input wire logic o_parity_even,
    input wire umc_pkg::umc_stop_e o_tx_stop,
    input wire logic o_sync_single,
    input wire logic o_transparent,
    input wire logic o_fill_escape,
    input wire logic o_escape_detect_en,
    input wire logic o_rate_tick
);
    import umc_pkg::*;
    logic mode_rd;
    assign mode_rd = !i_ce_b && !i_write && i_addr == `UMC_ADDR_MODE;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    property p_sync; o_sync_mode |-> o_tx_factor == UMC_F1X && o_rx_factor == UMC_F1X; endproperty
    a_sync: assert property (p_sync) else $error("sync factor not 1x");
    property p_int; !o_sync_mode && o_rx_clk_pin_oe |-> o_rx_factor == UMC_F16X; endproperty
    a_int: assert property (p_int) else $error("internal clock factor not 16x");
    property p_len; o_char_bits inside {[4'h5:4'h8]}; endproperty
    a_len: assert property (p_len) else $error("char length out of range");
    property p_par; !o_parity_en |-> !o_parity_even; endproperty
    a_par: assert property (p_par) else $error("parity type without parity");
    property p_stop; o_sync_mode |-> o_tx_stop == UMC_STOP_BAD; endproperty
    a_stop: assert property (p_stop) else $error("stop code in sync mode");
    property p_half; !o_sync_mode && o_tx_factor == UMC_F1X |-> o_tx_stop != UMC_STOP_1P5; endproperty
    a_half: assert property (p_half) else $error("half stop at 1x");
    property p_single; o_sync_single || o_transparent |-> o_sync_mode; endproperty
    a_single: assert property (p_single) else $error("sync framing in async");
    property p_esc; o_escape_detect_en == (o_transparent && !o_parity_en) && o_fill_escape == o_transparent; endproperty
    a_esc: assert property (p_esc) else $error("escape controls wrong");
    property p_rd; mode_rd |=> o_rdata_oe; endproperty
    a_rd: assert property (p_rd) else $error("mode read gave no data");
    property p_nord; !mode_rd |=> !o_rdata_oe && o_rdata == 8'h00; endproperty
    a_nord: assert property (p_nord) else $error("data bus driven without read");
    property p_tick; o_rate_tick |=> !o_rate_tick [*8]; endproperty
    a_tick: assert property (p_tick) else $error("rate tick too close");
endmodule
bind umc_mode_rate umc_mode_rate_chk u_chk (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_ce_b(i_ce_b),
    .i_write(i_write), .i_addr(i_addr), .o_rdata(o_rdata), .o_rdata_oe(o_rdata_oe),
    .o_rx_clk_pin_oe(o_rx_clk_pin_oe), .o_sync_mode(o_sync_mode), .o_tx_factor(o_tx_factor),
    .o_rx_factor(o_rx_factor), .o_char_bits(o_char_bits), .o_parity_en(o_parity_en),
    .o_parity_even(o_parity_even), .o_tx_stop(o_tx_stop), .o_sync_single(o_sync_single),
    .o_transparent(o_transparent), .o_fill_escape(o_fill_escape),
    .o_escape_detect_en(o_escape_detect_en), .o_rate_tick(o_rate_tick));
`default_nettype wire

// ### tb/umc_mode_rate_tb.sv
// testbench for the mode and rate block
`timescale 1ns/1ps
`default_nettype none
`include "umc_defines.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module umc_mode_rate_tb;
    import umc_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic ref_clk = 1'b0;
    logic ce_b = 1'b1;
    logic wr = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic run = 1'b0;
    logic txi, rxi, oe, txp, txoe, rxp, rxoe, txl, rxl, syn, pen, pev, sgl, trn, fil, stp, det, tick;
    logic [7:0] rdata;
    logic [3:0] cb;
    umc_factor_e txf, rxf;
    umc_stop_e txs, rxs;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    always #4 i_clock = ~i_clock;
    // rate reference clock of its own phase
    initial begin
        #3.3;
        forever #40 ref_clk = ~ref_clk;
    end
    umc_far_end u_far (.i_run(run), .o_tx_clk(txi), .o_rx_clk(rxi));
    umc_mode_rate i_dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_rate_ref_clk(ref_clk), .i_ce_b(ce_b),
        .i_write(wr), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rdata_oe(oe),
        .i_tx_clk_pin(txi), .o_tx_clk_pin(txp), .o_tx_clk_pin_oe(txoe), .i_rx_clk_pin(rxi),
        .o_rx_clk_pin(rxp), .o_rx_clk_pin_oe(rxoe), .o_tx_clk_level(txl), .o_rx_clk_level(rxl),
        .o_sync_mode(syn), .o_tx_factor(txf), .o_rx_factor(rxf), .o_char_bits(cb), .o_parity_en(pen),
        .o_parity_even(pev), .o_tx_stop(txs), .o_rx_stop(rxs), .o_sync_single(sgl), .o_transparent(trn),
        .o_fill_escape(fil), .o_escape_strip_en(stp), .o_escape_detect_en(det), .o_rate_tick(tick));
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // one bus access, result sampled mid cycle after the taking edge
    task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d);
        @(posedge i_clock);
        ce_b <= 1'b0;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge i_clock);
        ce_b <= 1'b1;
        @(negedge i_clock);
    endtask
    task automatic rdchk(input logic [7:0] e);
        acc(1'b0, `UMC_ADDR_MODE, 8'h00);
        `CHK("rdata_oe", 1'b1, oe)
        `CHK("rdata", e, rdata)
    endtask
    task automatic setm(input logic [7:0] m1, input logic [7:0] m2);
        acc(1'b1, `UMC_ADDR_MODE, m1);
        acc(1'b1, `UMC_ADDR_MODE, m2);
        repeat (3) @(posedge i_clock);
        @(negedge i_clock);
    endtask
    task automatic t_regs();
        rdchk(8'h00);
        rdchk(8'h00);
        acc(1'b1, `UMC_ADDR_MODE, 8'h5a);
        acc(1'b1, `UMC_ADDR_MODE, 8'hc3);
        acc(1'b1, 2'h0, 8'hff);
        acc(1'b1, `UMC_ADDR_MODE, 8'h96);
        rdchk(8'hc3);
        acc(1'b0, `UMC_ADDR_CMD, 8'h00);
        `CHK("cmd_oe", 1'b0, oe)
        rdchk(8'h96);
        rdchk(8'hc3);
        $display("t_regs done");
    endtask
    task automatic t_fmt();
        logic [2:0] j;
        logic [1:0] s;
        logic sy;
        umc_factor_e fx, etx, erx;
        umc_stop_e es;
        for (int k = 0; k < 8; k++) begin
            j = k[2:0];
            s = {j[2], j[2] ^ j[0]};
            sy = j[1:0] == 2'h0;
            setm({s, j[1], j[0], j[1:0], j[1:0]}, j[0] ? 8'h10 : 8'h20);
            fx = j[1:0] == 2'h3 ? UMC_F64X : j[1:0] == 2'h2 ? UMC_F16X : UMC_F1X;
            etx = sy ? UMC_F1X : j[0] ? fx : UMC_F16X;
            erx = sy ? UMC_F1X : j[0] ? UMC_F16X : fx;
            es = sy ? UMC_STOP_BAD : umc_stop_e'(s);
            `CHK("sync", sy, syn)
            `CHK("tx_factor", etx, txf)
            `CHK("rx_factor", erx, rxf)
            `CHK("char_bits", 4'h5 + {2'h0, j[1:0]}, cb)
            `CHK("parity_en", j[0], pen)
            `CHK("parity_even", j[0] & j[1], pev)
            `CHK("rx_stop", es, rxs)
            `CHK("tx_stop", (es == UMC_STOP_1P5 && etx == UMC_F1X) ? UMC_STOP_1 : es, txs)
            `CHK("single", sy & s[1], sgl)
            `CHK("transp", sy & s[0], trn)
            `CHK("strip", sy & s[0], stp)
            `CHK("detect", sy & s[0] & ~j[0], det)
            `CHK("tx_oe", ~j[0], txoe)
            `CHK("rx_oe", j[0], rxoe)
        end
        $display("t_fmt done");
    endtask
    task automatic t_rate(input logic [3:0] code, input int div);
        realtime t0;
        setm(8'h02, {4'h3, code});
        repeat (2) @(posedge txp);
        t0 = $realtime;
        @(posedge txp);
        `CHK("pin_period", 16 * div, int'(($realtime - t0) / 80.0))
        `CHK("pin_oe", 1'b1, txoe)
        `CHK("rx_pin_oe", 1'b1, rxoe)
        $display("t_rate done");
    endtask
    task automatic t_ext();
        setm(8'h02, 8'h00);
        `CHK("tx_oe", 1'b0, txoe)
        run <= 1'b1;
        @(negedge txl);
        @(negedge i_clock);
        `CHK("rx_level", 1'b0, rxl)
        run <= 1'b0;
        repeat (40) @(posedge i_clock);
        `CHK("tx_level", 1'b1, txl)
        $display("t_ext done");
    endtask
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (8) @(posedge i_clock);
        i_rst_b <= 1'b1;
        t_regs();
        t_fmt();
        t_rate(4'hf, 16);
        t_rate(4'he, 33);
        t_ext();
        conclude();
    end
endmodule
`default_nettype wire
